// ==== hdl/lhp_pkg.sv ====
package lhp_pkg;
   localparam int unsigned LHP_DW         = 8;
   localparam int unsigned LHP_FW         = 9;
   localparam int unsigned LHP_FIFO_DEPTH = 4;
   localparam int unsigned LHP_FIFO_AW    = 2;
   localparam int unsigned LHP_SER_CW     = 3;
   localparam int unsigned LHP_SER_DI_BIT = 7;
   localparam int unsigned LHP_SER_CK_BIT = 6;
   localparam logic [2:0]  LHP_SER_LAST   = 3'h7;
   localparam logic [2:0]  LHP_SER_ZERO   = 3'h0;
   localparam logic [7:0]  LHP_OE_OFF     = 8'hFF;
   localparam logic [7:0]  LHP_OE_ON      = 8'h00;
   localparam logic [7:0]  LHP_BYTE_RST   = 8'h00;

   typedef enum logic [1:0]
   {
      LHP_PH_IDLE  = 2'b00,
      LHP_PH_WRITE = 2'b01,
      LHP_PH_READ  = 2'b10
   } lhp_phase_t;

   function automatic logic lhp_fell(input logic prev, input logic cur);
      lhp_fell = prev & ~cur;
   endfunction

   function automatic logic lhp_rose(input logic prev, input logic cur);
      lhp_rose = ~prev & cur;
   endfunction
endpackage

// ==== hdl/lhp_fifo.sv ====
`timescale 1ns/100ps
module lhp_fifo
#(
   parameter int unsigned W  = 9,
   parameter int unsigned D  = 4,
   parameter int unsigned AW = 2
)
(
   input  wire logic          clk_sys,
   input  wire logic          rst,
   input  wire logic          in_valid,
   output logic               in_ready,
   input  wire logic [W-1:0]  in_data,
   output logic               out_valid,
   input  wire logic          out_ready,
   output logic      [W-1:0]  out_data
);
   import lhp_pkg::*;

   localparam logic [AW:0] FULL_CNT = (AW+1)'(D);
   localparam logic [AW:0] ZERO_CNT = '0;
   localparam logic [AW-1:0] LAST_IX = AW'(D - 1);

   logic [W-1:0]  mem_r [D];
   logic [AW-1:0] wr_ix_r;
   logic [AW-1:0] rd_ix_r;
   logic [AW:0]   cnt_r;
   logic          push;
   logic          pop;

   assign in_ready  = (cnt_r != FULL_CNT);
   assign out_valid = (cnt_r != ZERO_CNT);
   assign out_data  = mem_r[rd_ix_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge clk_sys)
   begin
      if (push)
         mem_r[wr_ix_r] <= in_data;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         wr_ix_r <= '0;
      else if (push)
         wr_ix_r <= (wr_ix_r == LAST_IX) ? '0 : wr_ix_r + 1'b1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         rd_ix_r <= '0;
      else if (pop)
         rd_ix_r <= (rd_ix_r == LAST_IX) ? '0 : rd_ix_r + 1'b1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         cnt_r <= '0;
      else if (push && !pop)
         cnt_r <= cnt_r + 1'b1;
      else if (pop && !push)
         cnt_r <= cnt_r - 1'b1;
   end
endmodule // lhp_fifo

// ==== hdl/lhp_serial_rx.sv ====
`timescale 1ns/100ps
module lhp_serial_rx
(
   input  wire logic         serial_clk,
   input  wire logic         cs_n_pin,
   input  wire logic         sys_rst,
   input  wire logic         ser_din,
   input  wire logic         dc_pin,
   output logic       [7:0]  hold_byte_r,
   output logic              hold_dc_r,
   output logic              byte_tog_r
);
   import lhp_pkg::*;

   logic [7:0] shift_r;
   logic [7:0] shift_nxt;
   logic [2:0] bit_cnt_r;

   assign shift_nxt = {shift_r[6:0], ser_din};

   // the serial clock stops outside frames, so deselect clears asynchronously
   always_ff @(posedge serial_clk or posedge cs_n_pin)
   begin
      if (cs_n_pin)
      begin
         shift_r   <= LHP_BYTE_RST;
         bit_cnt_r <= LHP_SER_ZERO;
      end
      else
      begin
         shift_r   <= shift_nxt;
         bit_cnt_r <= bit_cnt_r + 1'b1;
      end
   end

   // byte and its type stay put until the next eighth edge
   always_ff @(posedge serial_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         hold_byte_r <= LHP_BYTE_RST;
         hold_dc_r   <= 1'b0;
         byte_tog_r  <= 1'b0;
      end
      else if (bit_cnt_r == LHP_SER_LAST)
      begin
         hold_byte_r <= shift_nxt;
         hold_dc_r   <= dc_pin;
         byte_tog_r  <= ~byte_tog_r;
      end
   end
endmodule // lhp_serial_rx

// ==== hdl/lhp_host_port.sv ====
`timescale 1ns/100ps
module lhp_host_port
(
   input  wire logic                    clk_sys,
   input  wire logic                    sys_rst,
   input  wire logic                    serial_clk,
   input  wire logic                    reset_in_low,
   input  wire logic                    par_ser_select,
   input  wire logic                    bus_style_select,
   input  wire logic                    chip_sel_n,
   input  wire logic                    data_command_select,
   input  wire logic                    rd_n_or_enable,
   input  wire logic                    wr_n_or_rw,
   input  wire logic [lhp_pkg::LHP_DW-1:0] host_data_bus_in,
   output logic      [lhp_pkg::LHP_DW-1:0] host_data_bus_out,
   output logic      [lhp_pkg::LHP_DW-1:0] host_data_bus_oe_n,
   output logic                         rx_valid,
   input  wire logic                    rx_ready,
   output logic      [lhp_pkg::LHP_DW-1:0] rx_byte,
   output logic                         rx_is_data,
   input  wire logic [lhp_pkg::LHP_DW-1:0] read_word,
   output logic                         read_done,
   output logic                         read_is_data,
   output logic                         write_overrun,
   output logic                         serial_mode,
   output logic                         port_reset
);
   import lhp_pkg::*;

   // two-stage synchronisers for every pin that reaches clk_sys logic
   // host holds data for cycles around each strobe, so lines sync singly
   logic        rstn_s1_r;
   logic        rstn_s2_r;
   logic        ps_s1_r;
   logic        ps_s2_r;
   logic        sty_s1_r;
   logic        sty_s2_r;
   logic        cs_s1_r;
   logic        cs_s2_r;
   logic        dc_s1_r;
   logic        dc_s2_r;
   logic        rde_s1_r;
   logic        rde_s2_r;
   logic        wrw_s1_r;
   logic        wrw_s2_r;
   logic [7:0]  dat_s1_r;
   logic [7:0]  dat_s2_r;
   logic        tog_s1_r;
   logic        tog_s2_r;

   logic        rst_int;
   logic        rde_d_r;
   logic        wrw_d_r;
   logic        tog_seen_r;
   logic        selected;
   logic        par_mode;
   logic        wr_event;
   logic        rd_active;
   logic        rd_end;
   logic        ser_event;

   logic [7:0]  cap_byte_r;
   logic        cap_dc_r;
   logic        cap_valid_r;
   logic        cap_take;
   logic        cap_load;
   logic        fifo_in_ready;
   logic        overrun_r;
   logic [7:0]  bus_out_r;
   logic [7:0]  bus_oe_n_r;
   logic        read_done_r;
   logic        read_dc_r;
   logic        rd_dc_r;
   lhp_phase_t  phase_r;
   lhp_phase_t  phase_nxt;

   logic [7:0]  ser_byte;
   logic        ser_dc;
   logic        ser_tog;
   logic [8:0]  fifo_out;

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         rstn_s1_r <= 1'b0;
         rstn_s2_r <= 1'b0;
         ps_s1_r   <= 1'b0;
         ps_s2_r   <= 1'b0;
         sty_s1_r  <= 1'b0;
         sty_s2_r  <= 1'b0;
         cs_s1_r   <= 1'b1;
         cs_s2_r   <= 1'b1;
         dc_s1_r   <= 1'b0;
         dc_s2_r   <= 1'b0;
         rde_s1_r  <= 1'b0;
         rde_s2_r  <= 1'b0;
         wrw_s1_r  <= 1'b0;
         wrw_s2_r  <= 1'b0;
         dat_s1_r  <= LHP_BYTE_RST;
         dat_s2_r  <= LHP_BYTE_RST;
         tog_s1_r  <= 1'b0;
         tog_s2_r  <= 1'b0;
      end
      else
      begin
         rstn_s1_r <= reset_in_low;
         rstn_s2_r <= rstn_s1_r;
         ps_s1_r   <= par_ser_select;
         ps_s2_r   <= ps_s1_r;
         sty_s1_r  <= bus_style_select;
         sty_s2_r  <= sty_s1_r;
         cs_s1_r   <= chip_sel_n;
         cs_s2_r   <= cs_s1_r;
         dc_s1_r   <= data_command_select;
         dc_s2_r   <= dc_s1_r;
         rde_s1_r  <= rd_n_or_enable;
         rde_s2_r  <= rde_s1_r;
         wrw_s1_r  <= wr_n_or_rw;
         wrw_s2_r  <= wrw_s1_r;
         dat_s1_r  <= host_data_bus_in;
         dat_s2_r  <= dat_s1_r;
         tog_s1_r  <= ser_tog;
         tog_s2_r  <= tog_s1_r;
      end
   end

   // level-sensitive: the port stays in reset for as long as the pin is low
   assign rst_int  = sys_rst | ~rstn_s2_r;
   assign selected = ~cs_s2_r;
   assign par_mode = ps_s2_r;

   always_ff @(posedge clk_sys)
   begin
      if (rst_int)
      begin
         rde_d_r <= 1'b0;
         wrw_d_r <= 1'b0;
      end
      else
      begin
         rde_d_r <= rde_s2_r;
         wrw_d_r <= wrw_s2_r;
      end
   end

   // style high: enable strobe with direction line, low: separate strobes
   always_comb
   begin
      if (sty_s2_r)
      begin
         wr_event  = lhp_fell(rde_d_r, rde_s2_r) & ~wrw_s2_r;
         rd_active = rde_s2_r & wrw_s2_r;
         rd_end    = lhp_fell(rde_d_r, rde_s2_r) & wrw_s2_r;
      end
      else
      begin
         wr_event  = lhp_fell(wrw_d_r, wrw_s2_r);
         rd_active = ~rde_s2_r;
         rd_end    = lhp_rose(rde_d_r, rde_s2_r);
      end
   end

   // a toggle flip marks a finished serial byte, its hold register settled
   assign ser_event = (tog_s2_r != tog_seen_r);

   // follows even in reset, so a byte finished during reset is never taken
   always_ff @(posedge clk_sys)
   begin
      if (rst_int)
         tog_seen_r <= tog_s2_r;
      else
         tog_seen_r <= tog_s2_r;
   end

   lhp_serial_rx u_serial_rx
   (
      .serial_clk  (serial_clk),
      .cs_n_pin    (chip_sel_n),
      .sys_rst     (sys_rst),
      .ser_din     (host_data_bus_in[LHP_SER_DI_BIT]),
      .dc_pin      (data_command_select),
      .hold_byte_r (ser_byte),
      .hold_dc_r   (ser_dc),
      .byte_tog_r  (ser_tog)
   );

   // capture stage: holds one byte until the fifo has room
   assign cap_take = selected & ((par_mode & wr_event) |
                                 (~par_mode & ser_event));

   // a new byte may enter the stage in the cycle the old one leaves it
   assign cap_load = cap_take & (~cap_valid_r | fifo_in_ready);

   always_ff @(posedge clk_sys)
   begin
      if (rst_int)
      begin
         cap_byte_r <= LHP_BYTE_RST;
         cap_dc_r   <= 1'b0;
      end
      else if (cap_load)
      begin
         if (par_mode)
         begin
            cap_byte_r <= dat_s2_r;
            cap_dc_r   <= dc_s2_r;
         end
         else
         begin
            cap_byte_r <= ser_byte;
            cap_dc_r   <= ser_dc;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst_int)
         cap_valid_r <= 1'b0;
      else if (cap_take)
         cap_valid_r <= 1'b1;
      else if (fifo_in_ready)
         cap_valid_r <= 1'b0;
   end

   // a byte that arrives while the capture stage is still blocked is dropped
   always_ff @(posedge clk_sys)
   begin
      if (rst_int)
         overrun_r <= 1'b0;
      else if (cap_take && cap_valid_r && !fifo_in_ready)
         overrun_r <= 1'b1;
   end

   lhp_fifo
   #(
      .W  (LHP_FW),
      .D  (LHP_FIFO_DEPTH),
      .AW (LHP_FIFO_AW)
   )
   u_fifo
   (
      .clk_sys   (clk_sys),
      .rst       (rst_int),
      .in_valid  (cap_valid_r),
      .in_ready  (fifo_in_ready),
      .in_data   ({cap_dc_r, cap_byte_r}),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (fifo_out)
   );

   assign rx_is_data = fifo_out[LHP_DW];
   assign rx_byte    = fifo_out[LHP_DW-1:0];

   // bus phase tracking for the read drive
   always_comb
   begin
      phase_nxt = phase_r;
      case (phase_r)
         LHP_PH_IDLE:
         begin
            if (selected && par_mode && rd_active)
               phase_nxt = LHP_PH_READ;
            else if (cap_take)
               phase_nxt = LHP_PH_WRITE;
         end
         LHP_PH_WRITE:
            phase_nxt = LHP_PH_IDLE;
         LHP_PH_READ:
         begin
            if (!selected || !par_mode || !rd_active)
               phase_nxt = LHP_PH_IDLE;
         end
         default:
            phase_nxt = LHP_PH_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst_int)
         phase_r <= LHP_PH_IDLE;
      else
         phase_r <= phase_nxt;
   end

   // drive all lines during a read, otherwise release every line
   always_ff @(posedge clk_sys)
   begin
      if (rst_int)
         bus_oe_n_r <= LHP_OE_OFF;
      else if (phase_nxt == LHP_PH_READ)
         bus_oe_n_r <= LHP_OE_ON;
      else
         bus_oe_n_r <= LHP_OE_OFF;
   end

   // read data is latched once at read start and stands for the whole read
   always_ff @(posedge clk_sys)
   begin
      if (rst_int)
         bus_out_r <= LHP_BYTE_RST;
      else if (phase_r == LHP_PH_IDLE && phase_nxt == LHP_PH_READ)
         bus_out_r <= read_word;
   end

   // the select is latched with the read data and passed to read_is_data one cycle later
   always_ff @(posedge clk_sys)
   begin
      if (rst_int)
         rd_dc_r <= 1'b0;
      else if (phase_r == LHP_PH_IDLE && phase_nxt == LHP_PH_READ)
         rd_dc_r <= dc_s2_r;
   end

   // one pulse per completed read, so the user side can advance its holder
   always_ff @(posedge clk_sys)
   begin
      if (rst_int)
      begin
         read_done_r <= 1'b0;
         read_dc_r   <= 1'b0;
      end
      else
      begin
         read_done_r <= (phase_r == LHP_PH_READ) & rd_end & selected;
         read_dc_r   <= rd_dc_r;
      end
   end

   // status outputs come straight from flops, except serial_mode, which inverts one, and port_reset, which also takes sys_rst directly
   assign host_data_bus_out  = bus_out_r;
   assign host_data_bus_oe_n = bus_oe_n_r;
   assign read_done          = read_done_r;
   assign read_is_data       = read_dc_r;
   assign write_overrun      = overrun_r;
   assign serial_mode        = ~ps_s2_r;
   assign port_reset         = rst_int;
endmodule // lhp_host_port

// ==== testbench/lhp_host_port_checker.sv ====
`timescale 1ns/100ps
module lhp_host_port_checker
(
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   input wire logic       par_ser_select,
   input wire logic       chip_sel_n,
   input wire logic       rx_ready,
   input wire logic [7:0] read_word,
   input wire logic [7:0] host_data_bus_out,
   input wire logic [7:0] host_data_bus_oe_n,
   input wire logic       rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic       rx_is_data,
   input wire logic       read_done,
   input wire logic       write_overrun,
   input wire logic       serial_mode,
   input wire logic       port_reset
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   sequence s_read_end;
      !host_data_bus_oe_n[0] ##1 host_data_bus_oe_n[0] && !port_reset;
   endsequence
   sequence s_head_wait;
      rx_valid && !rx_ready && !port_reset ##1 !port_reset;
   endsequence
   a_desel_hiz: assert property (
      chip_sel_n[*4] |-> host_data_bus_oe_n == 8'hFF)
      else $error("bus driven while deselected");
   a_serial_quiet: assert property (
      serial_mode[*2] |-> host_data_bus_oe_n == 8'hFF)
      else $error("bus driven in serial mode");
   a_read_data: assert property (
      $fell(host_data_bus_oe_n[0]) |-> host_data_bus_out == $past(read_word))
      else $error("read data does not match word");
   a_read_end: assert property (s_read_end |-> read_done)
      else $error("read ended without done pulse");
   a_done_pulse: assert property (read_done |=> !read_done)
      else $error("read done longer than one cycle");
   a_reset_clear: assert property (
      port_reset[*2] |-> host_data_bus_oe_n == 8'hFF && !rx_valid
         && !write_overrun)
      else $error("outputs not cleared in reset");
   a_head_hold: assert property (
      s_head_wait |-> rx_valid && $stable(rx_byte) && $stable(rx_is_data))
      else $error("head byte changed without pop");
   a_mode_follow: assert property (
      (!port_reset && $stable(par_ser_select))[*4]
         |-> serial_mode == !par_ser_select)
      else $error("serial mode does not follow select");
endmodule // lhp_host_port_checker

bind lhp_host_port lhp_host_port_checker i_chk
(
   .clk_sys(clk_sys), .sys_rst(sys_rst), .par_ser_select(par_ser_select),
   .chip_sel_n(chip_sel_n), .rx_ready(rx_ready), .read_word(read_word),
   .host_data_bus_out(host_data_bus_out),
   .host_data_bus_oe_n(host_data_bus_oe_n), .rx_valid(rx_valid),
   .rx_byte(rx_byte), .rx_is_data(rx_is_data), .read_done(read_done),
   .write_overrun(write_overrun), .serial_mode(serial_mode),
   .port_reset(port_reset)
);

// ==== testbench/lhp_host_model.sv ====
`timescale 1ns/100ps
module lhp_host_model
(
   input  wire logic       clk_sys,
   input  wire logic [7:0] dev_out,
   input  wire logic [7:0] dev_oe_n,
   output logic            cs_n,
   output logic            dc,
   output logic            strb_a,
   output logic            strb_b,
   output logic      [7:0] bus
);
   logic [7:0] drv;
   logic       en;
   // device wins; a released host line shows the inverse of its last value
   always_comb
      for (int i = 0; i < 8; i++)
         bus[i] = !dev_oe_n[i] ? dev_out[i] : en ? drv[i] : ~drv[i];
   initial {cs_n, dc, strb_a, strb_b, en, drv} = {4'hB, 1'b1, 8'h00};
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic start(input logic sty, input logic sel_n,
                        input logic d_c);
      strb_a = ~sty;
      strb_b = 1;
      step(4);
      cs_n = sel_n;
      dc = d_c;
      step(4);
   endtask
   // style 1 pulses the enable with direction low; style 0 pulses write
   task automatic wr(input logic sty, input logic sel_n, input logic d_c,
                     input logic [7:0] b);
      drv = b;
      en = 1;
      start(sty, sel_n, d_c);
      strb_b = 0;
      step(5);
      strb_a = 1;
      step(5);
      strb_a = ~sty;
      step(5);
      strb_b = 1;
      step(4);
      cs_n = 1;
   endtask
   task automatic rd(input logic sty, input logic sel_n, input logic d_c,
                     output logic [8:0] got);
      start(sty, sel_n, d_c);
      strb_a = sty;
      en = 0;
      step(6);
      got = {dev_oe_n[0], bus};
      strb_a = ~sty;
      en = 1;
      step(5);
      cs_n = 1;
   endtask
   // serial clock idles low and runs only inside a frame
   task automatic ser(input logic d_c, input logic [7:0] b, input int n);
      drv[6] = 0;
      cs_n = 0;
      step(3);
      for (int i = 7; i > 7 - n; i--)
      begin
         drv[7] = b[i];
         drv[5:0] = ~drv[5:0];
         dc = (i == 0) ? d_c : ~d_c;
         #3 drv[6] = 1;
         #3 drv[6] = 0;
      end
      step(8);
      cs_n = 1;
      step(4);
   endtask
endmodule // lhp_host_model

// ==== testbench/lhp_host_port_test.sv ====
`timescale 1ns/100ps
module lhp_host_port_test;
   logic       clk_sys, sys_rst, reset_in_low, par_ser_select;
   logic       bus_style_select, rx_ready, cs_n, dc, h_a, h_b;
   logic [7:0] read_word, bus, bus_out, oe_n, rx_byte;
   logic       rx_valid, rx_is_data, read_done, read_is_data;
   logic       write_overrun, serial_mode, port_reset;
   logic [8:0] got;
   int         checks, bad_count;

   lhp_host_port i_dut
   (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .serial_clk(bus[6]),
      .reset_in_low(reset_in_low), .par_ser_select(par_ser_select),
      .bus_style_select(bus_style_select), .chip_sel_n(cs_n),
      .data_command_select(dc), .rd_n_or_enable(h_a), .wr_n_or_rw(h_b),
      .host_data_bus_in(bus), .host_data_bus_out(bus_out),
      .host_data_bus_oe_n(oe_n), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_byte(rx_byte), .rx_is_data(rx_is_data), .read_word(read_word),
      .read_done(read_done), .read_is_data(read_is_data),
      .write_overrun(write_overrun), .serial_mode(serial_mode),
      .port_reset(port_reset)
   );
   lhp_host_model i_host
   (
      .clk_sys(clk_sys), .dev_out(bus_out), .dev_oe_n(oe_n), .cs_n(cs_n),
      .dc(dc), .strb_a(h_a), .strb_b(h_b), .bus(bus)
   );

   initial
   begin
      clk_sys = 0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: %h vs %h", $time, seen, exp);
      end
   endtask

   task automatic pop(input logic [8:0] exp);
      for (int n = 0; n < 40 && rx_valid !== 1'b1; n++)
         i_host.step(1);
      check({rx_is_data, rx_byte}, exp);
      rx_ready = 1;
      i_host.step(1);
      rx_ready = 0;
      i_host.step(1);
   endtask

   task automatic t_par_write;
      for (int m = 0; m < 4; m++)
      begin
         bus_style_select = m[1];
         i_host.wr(m[1], 1'b0, m[0], 8'hA5 ^ 8'(m));
         pop({m[0], 8'hA5 ^ 8'(m)});
      end
   endtask

   task automatic t_par_read;
      for (int m = 0; m < 2; m++)
      begin
         bus_style_select = m[0];
         read_word = 8'h3C ^ 8'(m);
         i_host.rd(m[0], 1'b0, m[0], got);
         check(got, {1'b0, 8'h3C ^ 8'(m)});
         check({8'h00, read_is_data}, 9'(m));
         check({1'b0, oe_n}, 9'h0FF);
      end
      bus_style_select = 0;
      i_host.wr(1'b0, 1'b1, 1'b1, 8'h77);
      i_host.rd(1'b0, 1'b1, 1'b1, got);
      check({8'h00, got[8]}, 9'h001);
      check({8'h00, rx_valid}, 9'h000);
   endtask

   task automatic t_fifo;
      for (int k = 0; k < 6; k++)
         i_host.wr(1'b0, 1'b0, 1'b1, 8'h10 + 8'(k));
      check({8'h00, write_overrun}, 9'h001);
      for (int k = 0; k < 5; k++)
         pop({1'b1, 8'h10 + 8'(k)});
      check({8'h00, rx_valid}, 9'h000);
   endtask

   task automatic t_pin_reset;
      i_host.wr(1'b0, 1'b0, 1'b0, 8'h42);
      reset_in_low = 0;
      i_host.step(5);
      check({7'h00, rx_valid, write_overrun}, 9'h000);
      reset_in_low = 1;
      i_host.step(5);
   endtask

   task automatic t_serial;
      par_ser_select = 0;
      i_host.step(5);
      i_host.ser(1'b0, 8'hC3, 8);
      pop(9'h0C3);
      i_host.ser(1'b1, 8'hFF, 5);
      i_host.ser(1'b1, 8'h5A, 8);
      pop(9'h15A);
      i_host.rd(1'b0, 1'b0, 1'b1, got);
      check({8'h00, got[8]}, 9'h001);
      par_ser_select = 1;
      i_host.step(5);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      #400000;
      bad_count++;
      test_done;
   end

   initial
   begin
      sys_rst = 1;
      reset_in_low = 1;
      par_ser_select = 1;
      bus_style_select = 0;
      rx_ready = 0;
      read_word = 8'h00;
      checks = 0;
      bad_count = 0;
      i_host.step(4);
      sys_rst = 0;
      i_host.step(4);
      check({1'b0, oe_n}, 9'h0FF);
      check({8'h00, rx_valid}, 9'h000);
      t_par_write;
      t_par_read;
      t_fifo;
      t_pin_reset;
      t_serial;
      test_done;
   end
endmodule // lhp_host_port_test
